/* File: core/sbc_consts.svh */
// Offsets, field positions, reset values and timing counts of the checker.
// Assumes a 12-bit byte register address and 8-bit register data.
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SBC_ADDR_SYNC_SETUP   12'h312
`define SBC_ADDR_DESER_SETUP  12'h314
`define SBC_ADDR_LANE_EN      12'h315
`define SBC_ADDR_TEST_CTRL    12'h316
`define SBC_ADDR_THR_LOW      12'h317
`define SBC_ADDR_THR_MID      12'h318
`define SBC_ADDR_THR_HIGH     12'h319
`define SBC_ADDR_CNT_LOW      12'h31A
`define SBC_ADDR_CNT_MID      12'h31B
`define SBC_ADDR_CNT_HIGH     12'h31C
`define SBC_ADDR_PASS         12'h31D

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SBC_SYNC_DUR_LSB      4
`define SBC_CTRL_SEL_LSB      4
`define SBC_CTRL_PAT_LSB      2
`define SBC_CTRL_START_BIT    1
`define SBC_CTRL_HOLD_BIT     0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SBC_RST_BYTE          8'h00
`define SBC_RST_PASS_BIT      1'b1

// ----------------------------------------------------------------------
// Sync error low durations
// ----------------------------------------------------------------------
`define SBC_DUR_HALF          2'h0
`define SBC_DUR_ONE           2'h1
`define SBC_SYNC_CYC_ONE      2'h1
`define SBC_SYNC_CYC_TWO      2'h2

`endif

/* File: core/sbc_lane_checker.sv */
// One lane: self-synchronising pattern check and saturating error counter.
// Assumes lane data on sys_clk, oldest bit in the MSB of each word.
`timescale 1ns/1ps

module sbc_lane_checker
  import sbc_pkg::*;
#(
  parameter int LANE_W = 8,
  parameter int CNT_W  = 24
)
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // Lane data and control
  input  wire logic [LANE_W-1:0] laneData,
  input  wire sbc_pattern_e      pattern,
  input  wire logic              countEn,
  input  wire logic              countClear,
  // Result
  output logic      [CNT_W-1:0]  errCount
);

  localparam int SUM_W = $clog2(LANE_W + 1);

  logic [30:0]      hist_q;
  logic [30:0]      hist_d;
  logic [CNT_W-1:0] errCount_q;
  logic [CNT_W-1:0] errCount_d;
  logic [SUM_W-1:0] errSum;
  logic [CNT_W:0]   sumWide;
  logic             rxBit;
  logic             predBit;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    hist_d  = hist_q;
    errSum  = '0;
    rxBit   = 1'b0;
    predBit = 1'b0;
    for (int i = LANE_W - 1; i >= 0; i--)
    begin
      rxBit = laneData[i];
      unique case (pattern)
        SBC_PAT_PRBS7:  predBit = hist_d[6] ^ hist_d[5];
        SBC_PAT_PRBS15: predBit = hist_d[14] ^ hist_d[13];
        SBC_PAT_PRBS31: predBit = hist_d[30] ^ hist_d[27];
        SBC_PAT_RSVD:   predBit = rxBit;
      endcase
      errSum = errSum + SUM_W'(rxBit ^ predBit);  // [R13]
      hist_d = {hist_d[29:0], rxBit};             // [R13]
    end
    sumWide    = {1'b0, errCount_q} + (CNT_W+1)'(errSum);
    errCount_d = errCount_q;
    if (countClear)
      errCount_d = '0;                            // [R08]
    else if (countEn)
      errCount_d = sumWide[CNT_W] ? '1 : sumWide[CNT_W-1:0];  // [R13]
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hist_q     <= '0;
      errCount_q <= '0;
    end
    else if (ce)
    begin
      hist_q     <= hist_d;
      errCount_q <= errCount_d;
    end
  end

  assign errCount = errCount_q;

endmodule // sbc_lane_checker

/* File: core/sbc_pkg.sv */
// Types shared by the checker top and its lane checkers.
// Assumes nothing of its surroundings.
package sbc_pkg;

  // ----------------------------------------------------------------------
  // Pattern choice, codes follow the register field
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SBC_PAT_PRBS7,
    SBC_PAT_PRBS15,
    SBC_PAT_PRBS31,
    SBC_PAT_RSVD
  } sbc_pattern_e;

  // ----------------------------------------------------------------------
  // Test state machine
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SBC_HELD,
    SBC_STOPPED,
    SBC_RUNNING
  } sbc_test_state_e;

endpackage

/* File: core/sbc_top.sv */
// Per-lane pattern error test with byte register port and sync error pulse.
// Assumes lane data, error flags and register port all on sys_clk.
//
// What this block does
// R01: Multiframe with link errors raises sync error
// R02: Sync error low half, one, two cycles
// R03: Host writes 0x01 to deserializer setup
// R04: Per-lane test enable, all off at reset
// R05: Select field picks lane count shown
// R06: Pattern select: PRBS7, PRBS15, PRBS31
// R07: Start bit runs test, counting only then
// R08: Hold bit resets state machine, counters
// R09: 24-bit threshold, three bytes, LSB first
// R10: Selected count low and mid bytes readable
// R11: Selected count high byte at third address
// R12: Pass bit per lane, count below threshold
// R13: Self-synchronising compare, saturating 24-bit counters
// R14: Transmitter sends pattern continuously during test
`timescale 1ns/1ps
`include "sbc_consts.svh"

module sbc_top
  import sbc_pkg::*;
#(
  parameter int LANES  = 8,
  parameter int LANE_W = 8,
  parameter int CNT_W  = 24
)
(
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  input  wire logic                    ce,
  // Register port
  input  wire logic [11:0]             regAddr,
  input  wire logic                    regWrEn,
  input  wire logic [7:0]              regWrData,
  input  wire logic                    regRdEn,
  output logic      [7:0]              regRdData,
  // Lane data
  input  wire logic [LANES*LANE_W-1:0] laneData,
  // Link error reports
  input  wire logic                    mfEnd,
  input  wire logic [LANES-1:0]        dispErr,
  input  wire logic [LANES-1:0]        notInTableErr,
  input  wire logic [LANES-1:0]        unexpCtrlErr,
  // Sync, setup and test status outputs
  output logic      [1:0]              linkSyncOutputN,
  output logic      [7:0]              deserSetupValue,
  output logic                         testRunning
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0]             syncSetup_q;
  logic [7:0]             syncSetup_d;
  logic [7:0]             deserSetup_q;
  logic [7:0]             deserSetup_d;
  logic [LANES-1:0]       laneEnable_q;
  logic [LANES-1:0]       laneEnable_d;
  logic [6:0]             testCtrl_q;
  logic [6:0]             testCtrl_d;
  logic [CNT_W-1:0]       threshold_q;
  logic [CNT_W-1:0]       threshold_d;
  logic [LANES-1:0]       passFlags_q;
  logic [LANES-1:0]       passFlags_d;
  logic [7:0]             rdData_q;
  logic [7:0]             rdData_d;
  sbc_test_state_e        state_q;
  sbc_test_state_e        state_d;
  logic                   mfErrSeen_q;
  logic                   mfErrSeen_d;
  logic [1:0]             syncCnt_q;
  logic [1:0]             syncCnt_d;
  logic                   halfMode_q;
  logic                   halfMode_d;
  logic                   startTgl_q;
  logic                   startTgl_d;
  logic                   seenTgl_q;
  logic                   seenTgl_d;
  logic                   linkErr;
  logic                   syncStart;
  logic                   syncLow;
  logic [1:0]             syncDur;
  logic [2:0]             countSel;
  sbc_pattern_e           pattern;
  logic                   testHold;
  logic                   testStart;
  logic [CNT_W-1:0]       laneCount [LANES];
  logic [CNT_W-1:0]       selCount;
  logic [LANES-1:0]       belowThr;

  // ----------------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------------
  assign syncDur   = syncSetup_q[`SBC_SYNC_DUR_LSB +: 2];
  assign countSel  = testCtrl_q[`SBC_CTRL_SEL_LSB +: 3];
  assign pattern   = sbc_pattern_e'(testCtrl_q[`SBC_CTRL_PAT_LSB +: 2]);  // [R06]
  assign testHold  = testCtrl_q[`SBC_CTRL_HOLD_BIT];
  assign testStart = testCtrl_q[`SBC_CTRL_START_BIT];

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_comb
  begin
    syncSetup_d  = syncSetup_q;
    deserSetup_d = deserSetup_q;
    laneEnable_d = laneEnable_q;
    testCtrl_d   = testCtrl_q;
    threshold_d  = threshold_q;
    if (regWrEn)
    begin
      unique case (regAddr)
        `SBC_ADDR_SYNC_SETUP:  syncSetup_d  = regWrData;
        `SBC_ADDR_DESER_SETUP: deserSetup_d = regWrData;                // [R03]
        `SBC_ADDR_LANE_EN:     laneEnable_d = regWrData[LANES-1:0];     // [R04]
        `SBC_ADDR_TEST_CTRL:   testCtrl_d   = regWrData[6:0];
        `SBC_ADDR_THR_LOW:     threshold_d[7:0]   = regWrData;          // [R09]
        `SBC_ADDR_THR_MID:     threshold_d[15:8]  = regWrData;          // [R09]
        `SBC_ADDR_THR_HIGH:    threshold_d[23:16] = regWrData;          // [R09]
        default:               ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      syncSetup_q  <= `SBC_RST_BYTE;
      deserSetup_q <= `SBC_RST_BYTE;                                    // [R03]
      laneEnable_q <= '0;                                               // [R04]
      testCtrl_q   <= '0;
      threshold_q  <= '0;                                               // [R09]
    end
    else if (ce)
    begin
      syncSetup_q  <= syncSetup_d;
      deserSetup_q <= deserSetup_d;
      laneEnable_q <= laneEnable_d;
      testCtrl_q   <= testCtrl_d;
      threshold_q  <= threshold_d;
    end
  end

  assign deserSetupValue = deserSetup_q;

  // ----------------------------------------------------------------------
  // Test state machine
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      SBC_HELD:    state_d = testHold ? SBC_HELD : SBC_STOPPED;         // [R08]
      SBC_STOPPED: state_d = testHold ? SBC_HELD
                           : (testStart ? SBC_RUNNING : SBC_STOPPED);   // [R07]
      SBC_RUNNING: state_d = testHold ? SBC_HELD
                           : (testStart ? SBC_RUNNING : SBC_STOPPED);   // [R07]
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      state_q <= SBC_HELD;
    else if (ce)
      state_q <= state_d;
  end

  assign testRunning = (state_q == SBC_RUNNING);

  // ----------------------------------------------------------------------
  // Lane checkers
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < LANES; g++)
  begin : gLane
    sbc_lane_checker #(
      .LANE_W (LANE_W),
      .CNT_W  (CNT_W)
    ) uChk (
      .sys_clk    (sys_clk),
      .nrst       (nrst),
      .ce         (ce),
      .laneData   (laneData[g*LANE_W +: LANE_W]),
      .pattern    (pattern),
      .countEn    (testRunning && laneEnable_q[g]),                    // [R04] [R07]
      .countClear (state_q == SBC_HELD),                               // [R08]
      .errCount   (laneCount[g])
    );
    assign belowThr[g] = (laneCount[g] < threshold_q);                 // [R12]
  end

  assign selCount = (32'(countSel) < LANES) ? laneCount[countSel] : '0;  // [R05]

  // ----------------------------------------------------------------------
  // Pass flags
  // ----------------------------------------------------------------------
  always_comb
  begin
    passFlags_d = passFlags_q;
    if (state_q == SBC_HELD)
      passFlags_d = {LANES{`SBC_RST_PASS_BIT}};                         // [R12]
    else if (testRunning)
      passFlags_d = belowThr;                                          // [R12]
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      passFlags_q <= {LANES{`SBC_RST_PASS_BIT}};                        // [R12]
    else if (ce)
      passFlags_q <= passFlags_d;
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  always_comb
  begin
    rdData_d = rdData_q;
    if (regRdEn)
    begin
      unique case (regAddr)
        `SBC_ADDR_SYNC_SETUP:  rdData_d = syncSetup_q;
        `SBC_ADDR_DESER_SETUP: rdData_d = deserSetup_q;
        `SBC_ADDR_LANE_EN:     rdData_d = 8'(laneEnable_q);
        `SBC_ADDR_TEST_CTRL:   rdData_d = {1'b0, testCtrl_q};
        `SBC_ADDR_THR_LOW:     rdData_d = threshold_q[7:0];
        `SBC_ADDR_THR_MID:     rdData_d = threshold_q[15:8];
        `SBC_ADDR_THR_HIGH:    rdData_d = threshold_q[23:16];
        `SBC_ADDR_CNT_LOW:     rdData_d = selCount[7:0];                // [R10]
        `SBC_ADDR_CNT_MID:     rdData_d = selCount[15:8];               // [R10]
        `SBC_ADDR_CNT_HIGH:    rdData_d = selCount[23:16];              // [R11]
        `SBC_ADDR_PASS:        rdData_d = 8'(passFlags_q);              // [R12]
        default:               rdData_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rdData_q <= 8'h00;
    else if (ce)
      rdData_q <= rdData_d;
  end

  assign regRdData = rdData_q;

  // ----------------------------------------------------------------------
  // Multiframe error gathering
  // ----------------------------------------------------------------------
  assign linkErr   = |(dispErr | notInTableErr | unexpCtrlErr);
  assign syncStart = mfEnd && (mfErrSeen_q || linkErr);                // [R01]

  always_comb
  begin
    mfErrSeen_d = mfErrSeen_q;
    if (mfEnd)
      mfErrSeen_d = 1'b0;                                              // [R01]
    else if (linkErr)
      mfErrSeen_d = 1'b1;                                              // [R01]
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      mfErrSeen_q <= 1'b0;
    else if (ce)
      mfErrSeen_q <= mfErrSeen_d;
  end

  // ----------------------------------------------------------------------
  // Sync error pulse
  // ----------------------------------------------------------------------
  always_comb
  begin
    syncCnt_d  = syncCnt_q;
    halfMode_d = halfMode_q;
    startTgl_d = startTgl_q;
    if (syncStart)
    begin
      halfMode_d = (syncDur == `SBC_DUR_HALF);                          // [R02]
      startTgl_d = ~startTgl_q;
      if ((syncDur == `SBC_DUR_HALF) || (syncDur == `SBC_DUR_ONE))
        syncCnt_d = `SBC_SYNC_CYC_ONE;                                  // [R02]
      else
        syncCnt_d = `SBC_SYNC_CYC_TWO;                                  // [R02]
    end
    else if (syncCnt_q != 2'h0)
      syncCnt_d = syncCnt_q - 2'h1;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      syncCnt_q  <= 2'h0;
      halfMode_q <= 1'b0;
      startTgl_q <= 1'b0;
    end
    else if (ce)
    begin
      syncCnt_q  <= syncCnt_d;
      halfMode_q <= halfMode_d;
      startTgl_q <= startTgl_d;
    end
  end

  // Falling edge copy cuts a half-cycle pulse at mid-cycle
  always_comb
  begin
    seenTgl_d = ce ? startTgl_q : seenTgl_q;
  end

  always_ff @(negedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      seenTgl_q <= 1'b0;
    else
      seenTgl_q <= seenTgl_d;
  end

  assign syncLow = (syncCnt_q != 2'h0)
                && !(halfMode_q && (seenTgl_q == startTgl_q));         // [R02]
  assign linkSyncOutputN = {2{~syncLow}};                              // [R02]

endmodule // sbc_top

/* File: tb/sbc_prbs_source.sv */
// Far-end transmitter model: same test pattern on every lane.
// Assumes one word per sys_clk, oldest bit in the word MSB.
`timescale 1ns/1ps
module sbc_prbs_source
  import sbc_pkg::*;
#(
  parameter int LANES  = 8,
  parameter int LANE_W = 8
)
(
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  // Pattern choice and bit flips
  input  wire sbc_pattern_e            pattern,
  input  wire logic [LANES-1:0]        flipReq,
  // Lane data
  output logic      [LANES*LANE_W-1:0] laneData
);
  logic [30:0]             histQ;
  logic [30:0]             histD;
  logic [LANES*LANE_W-1:0] dataD;

  // Sequence runs without pause, flips only on the wire
  always_comb
  begin
    histD = histQ;
    for (int i = LANE_W - 1; i >= 0; i--)
    begin
      case (pattern)
        SBC_PAT_PRBS7:  histD = {histD[29:0], histD[6] ^ histD[5]};
        SBC_PAT_PRBS15: histD = {histD[29:0], histD[14] ^ histD[13]};
        default:        histD = {histD[29:0], histD[30] ^ histD[27]};
      endcase
      dataD[i] = histD[0];
    end
    for (int g = LANES - 1; g >= 0; g--)
      dataD[g*LANE_W +: LANE_W] = dataD[LANE_W-1:0] ^ LANE_W'(flipReq[g]);
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      histQ    <= 31'h7FFFFFFF;
      laneData <= '0;
    end
    else
    begin
      histQ    <= histD;
      laneData <= dataD;
    end
  end
endmodule // sbc_prbs_source

/* File: tb/sbc_top_props.sv */
// Port assertions for sbc_top, attached by bind.
// Assumes one sys_clk domain; ce low only around a single write.
`timescale 1ns/1ps
`include "sbc_consts.svh"
module sbc_top_props
  import sbc_pkg::*;
#(
  parameter int LANES  = 8,
  parameter int LANE_W = 8,
  parameter int CNT_W  = 24
)
(
  // Clock and reset
  input wire logic                    sys_clk,
  input wire logic                    nrst,
  input wire logic                    ce,
  // Register port
  input wire logic [11:0]             regAddr,
  input wire logic                    regWrEn,
  input wire logic [7:0]              regWrData,
  input wire logic                    regRdEn,
  input wire logic [7:0]              regRdData,
  // Lane data and link errors
  input wire logic [LANES*LANE_W-1:0] laneData,
  input wire logic                    mfEnd,
  input wire logic [LANES-1:0]        dispErr,
  input wire logic [LANES-1:0]        notInTableErr,
  input wire logic [LANES-1:0]        unexpCtrlErr,
  // Outputs
  input wire logic [1:0]              linkSyncOutputN,
  input wire logic [7:0]              deserSetupValue,
  input wire logic                    testRunning
);
  logic [1:0] durQ;
  logic [1:0] durD;

  // Shadow of the sync low duration
  always_comb
  begin
    durD = durQ;
    if (ce && regWrEn && regAddr == `SBC_ADDR_SYNC_SETUP)
      durD = regWrData[5:4];
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      durQ <= 2'h0;
    else
      durQ <= durD;
  end

  sequence s_wr(a);
    ce && regWrEn && regAddr == a;
  endsequence
  sequence s_rd(a);
    ce && regRdEn && regAddr == a;
  endsequence
  sequence s_low2;
    !linkSyncOutputN[0] ##1 !linkSyncOutputN[0];
  endsequence

  a_sync_pair_equal: assert property (@(negedge sys_clk) disable iff (!nrst)
    linkSyncOutputN[0] == linkSyncOutputN[1]) else $error("sync outputs differ");
  a_sync_after_end: assert property (@(negedge sys_clk) disable iff (!nrst)
    $fell(linkSyncOutputN[0]) |-> $past(mfEnd)) else $error("sync low without frame end");
  a_sync_two_long: assert property (@(negedge sys_clk) disable iff (!nrst)
    $fell(linkSyncOutputN[0]) && durQ >= 2'h2 |-> s_low2) else $error("sync pulse too short");
  a_sync_short: assert property (@(negedge sys_clk) disable iff (!nrst)
    $fell(linkSyncOutputN[0]) && durQ < 2'h2 && !mfEnd |=> linkSyncOutputN[0])
    else $error("sync pulse too long");
  a_read_stands: assert property (@(posedge sys_clk) disable iff (!nrst)
    !$past(regRdEn) |-> $stable(regRdData)) else $error("read data moved without read");
  a_deser_follows: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_wr(`SBC_ADDR_DESER_SETUP) |=> deserSetupValue == $past(regWrData))
    else $error("setup value not updated");
  a_thr_readback: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_wr(`SBC_ADDR_THR_MID) ##2 s_rd(`SBC_ADDR_THR_MID) |=> regRdData == $past(regWrData, 3))
    else $error("threshold byte readback wrong");
  a_start_runs: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_wr(`SBC_ADDR_TEST_CTRL) ##0 regWrData[1:0] == 2'h2 |-> ##2 testRunning)
    else $error("test not running after start");
  a_hold_stops: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_wr(`SBC_ADDR_TEST_CTRL) ##0 regWrData[0] |-> ##2 !testRunning)
    else $error("test running while held");
endmodule // sbc_top_props

bind sbc_top sbc_top_props #(.LANES(LANES), .LANE_W(LANE_W), .CNT_W(CNT_W)) u_props (
  .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .regAddr(regAddr), .regWrEn(regWrEn),
  .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .laneData(laneData),
  .mfEnd(mfEnd), .dispErr(dispErr), .notInTableErr(notInTableErr),
  .unexpCtrlErr(unexpCtrlErr), .linkSyncOutputN(linkSyncOutputN),
  .deserSetupValue(deserSetupValue), .testRunning(testRunning));

/* File: tb/serdes_prbs_ber_checker_test.sv */
// Self-checking bench for the lane pattern error test block.
// Assumes the bound checker and the pattern source model.
`timescale 1ns/1ps
`include "sbc_consts.svh"
module serdes_prbs_ber_checker_test
  import sbc_pkg::*;
;
  logic         sys_clk = 1'b0;
  logic         nrst = 1'b0;
  logic         ceOn = 1'b1;
  logic [11:0]  regAddr = 12'h000;
  logic         regWrEn = 1'b0;
  logic [7:0]   regWrData = 8'h00;
  logic         regRdEn = 1'b0;
  logic [7:0]   regRdData;
  logic [63:0]  laneData;
  logic         mfEnd = 1'b0;
  logic [7:0]   dispErr = 8'h00;
  logic [7:0]   notInTableErr = 8'h00;
  logic [7:0]   unexpCtrlErr = 8'h00;
  logic [1:0]   linkSyncOutputN;
  logic [7:0]   deserSetupValue;
  logic         testRunning;
  sbc_pattern_e pattern = SBC_PAT_PRBS7;
  logic [7:0]   flipReq = 8'h00;
  int           nFail = 0;
  int           numChecks = 0;
  int           cycles = 0;

  sbc_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .ce(ceOn), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .laneData(laneData), .mfEnd(mfEnd), .dispErr(dispErr), .notInTableErr(notInTableErr),
    .unexpCtrlErr(unexpCtrlErr), .linkSyncOutputN(linkSyncOutputN),
    .deserSetupValue(deserSetupValue), .testRunning(testRunning));
  sbc_prbs_source src_u (.sys_clk(sys_clk), .nrst(nrst), .pattern(pattern),
    .flipReq(flipReq), .laneData(laneData));

  always #12.5 sys_clk = ~sys_clk;

  task automatic completeRun();
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      nFail++;
      completeRun();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      nFail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    @(posedge sys_clk);
    check(regRdData, exp);
  endtask

  task automatic inject(input logic [7:0] lanes);
    flipReq <= lanes;
    @(posedge sys_clk);
    flipReq <= 8'h00;
    repeat (20) @(posedge sys_clk);
  endtask

  task automatic test_reset_values();
    for (logic [11:0] a = 12'h312; a <= 12'h31D; a++)
      rd(a, (a == `SBC_ADDR_PASS) ? 8'hFF : 8'h00);
    rd(12'h300, 8'h00);
  endtask

  task automatic test_registers();
    wr(`SBC_ADDR_DESER_SETUP, 8'h01);
    check(deserSetupValue, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      wr(`SBC_ADDR_THR_LOW + 12'(i), 8'(8'h11 * (i + 1)));
      rd(`SBC_ADDR_THR_LOW + 12'(i), 8'(8'h11 * (i + 1)));
    end
    wr(`SBC_ADDR_CNT_LOW, 8'hFF);
    rd(`SBC_ADDR_CNT_LOW, 8'h00);
    wr(`SBC_ADDR_LANE_EN, 8'hDF);
    rd(`SBC_ADDR_LANE_EN, 8'hDF);
    wr(`SBC_ADDR_THR_LOW, 8'h04);
    wr(`SBC_ADDR_THR_MID, 8'h00);
    wr(`SBC_ADDR_THR_HIGH, 8'h00);
  endtask

  task automatic test_clock_enable();
    ceOn <= 1'b0;
    wr(`SBC_ADDR_THR_LOW, 8'h55);
    ceOn <= 1'b1;
    rd(`SBC_ADDR_THR_LOW, 8'h04);
  endtask

  task automatic test_no_pattern();
    wr(`SBC_ADDR_TEST_CTRL, 8'h2D);
    wr(`SBC_ADDR_TEST_CTRL, 8'h2E);
    inject(8'h04);
    rd(`SBC_ADDR_CNT_LOW, 8'h00);
    wr(`SBC_ADDR_TEST_CTRL, 8'h2C);
  endtask

  task automatic test_pattern(input sbc_pattern_e p);
    logic [7:0] ctl;
    ctl = {1'b0, 3'h2, p, 2'h0};
    wr(`SBC_ADDR_TEST_CTRL, ctl | 8'h01);
    pattern <= p;
    repeat (8) @(posedge sys_clk);
    rd(`SBC_ADDR_CNT_LOW, 8'h00);
    rd(`SBC_ADDR_PASS, 8'hFF);
    wr(`SBC_ADDR_TEST_CTRL, ctl | 8'h02);
    repeat (8) @(posedge sys_clk);
    check({7'h00, testRunning}, 8'h01);
    inject(8'h24);
    rd(`SBC_ADDR_CNT_LOW, 8'h03);
    rd(`SBC_ADDR_CNT_MID, 8'h00);
    rd(`SBC_ADDR_CNT_HIGH, 8'h00);
    rd(`SBC_ADDR_PASS, 8'hFF);
    wr(`SBC_ADDR_TEST_CTRL, ctl ^ 8'h72);
    rd(`SBC_ADDR_CNT_LOW, 8'h00);
    inject(8'h04);
    rd(`SBC_ADDR_PASS, 8'hFB);
    wr(`SBC_ADDR_TEST_CTRL, ctl);
    inject(8'h04);
    rd(`SBC_ADDR_CNT_LOW, 8'h06);
  endtask

  task automatic test_sync(input logic [1:0] dur, input int kind, input int expLow);
    int lows;
    lows = 0;
    wr(`SBC_ADDR_SYNC_SETUP, {2'h0, dur, 4'h0});
    case (kind)
      0: dispErr <= 8'h08;
      1: notInTableErr <= 8'h01;
      2: unexpCtrlErr <= 8'h80;
      default: ;
    endcase
    @(posedge sys_clk);
    dispErr <= 8'h00;
    notInTableErr <= 8'h00;
    unexpCtrlErr <= 8'h00;
    repeat (3) @(posedge sys_clk);
    mfEnd <= 1'b1;
    @(posedge sys_clk);
    mfEnd <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      #5;
      if (linkSyncOutputN !== 2'b11)
        lows++;
      #7.5;
    end
    @(posedge sys_clk);
    check(8'(lows), 8'(expLow));
  endtask

  initial
  begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    test_reset_values();
    test_registers();
    test_clock_enable();
    test_pattern(SBC_PAT_PRBS7);
    test_pattern(SBC_PAT_PRBS15);
    test_pattern(SBC_PAT_PRBS31);
    test_no_pattern();
    test_sync(2'h0, 0, 1);
    test_sync(2'h1, 1, 2);
    test_sync(2'h2, 2, 4);
    test_sync(2'h3, 0, 4);
    test_sync(2'h1, 3, 0);
    completeRun();
  end
endmodule // serdes_prbs_ber_checker_test
